// File: hdl/burst_sram_access.sv
// Synchronous burst SRAM access logic: strobes, burst, writes, output modes
//
// How it works
// R1: Address, data and controls register on rising edge; output enable and straps do not.
// R2: Controller strobe low aborts burst, loads address, starts read, write or deselect.
// R3: Processor strobe aborts and loads too, but is ignored while primary enable high.
// R4: Without strobes, advance low steps the burst address, advance high holds it.
// R5: Burst counter is two bits on the low address bits; upper bits stay.
// R6: Host wires the two lowest address inputs to its two lowest address bits.
// R7: Static order strap: low linear burst, high interleaved burst.
// R8: Static mode strap, unregistered: low flow-through, high pipelined reads.
// R9: Pipelined reads pass an output register, adding one cycle of latency.
// R10: Flow-through reads drive array data combinationally in the same cycle.
// R11: Eight byte lanes; a lane writes when its byte write and write enable are low.
// R12: Global write low, or all byte writes and write enable low, writes all lanes.
// R13: Cycle is a write on global write, or write enable with any byte write.
// R14: Writes launch on the clock edge and are timed internally.
// R15: Primary enable high ignores processor strobe; controller strobe then deselects.
// R16: Access starts only on enables low, high, low; otherwise deselect and float.
// R17: Output enable acts without the clock: drive while low in reads, float when high.
// R18: Host negates output enable before a write after a read, until it completes.
// R19: Byte-write-only hosts tie global write high and write enable low.
// R20: Memory holds 256K words of 72 bits on eighteen registered address inputs.
// R21: Processor-strobe cycles are reads; controller-strobe cycles follow write inputs.
// R22: Interleaved bursts XOR the starting low bits with step counts 01, 10, 11.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "burst_sram_defines.svh"

module burst_sram_access
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int LANE_W = `SRAM_LANE_W
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Address and burst control
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  // Chip enables
  input wire logic chip_en_primary_n_in,
  input wire logic chip_en_depth_hi_in,
  input wire logic chip_en_depth_lo_n_in,
  // Write controls
  input wire logic global_write_n_in,
  input wire logic write_en_n_in,
  input wire logic [LANES-1:0] byte_write_n_in,
  // Asynchronous output enable and static straps
  input wire logic output_en_n_in,
  input wire logic burst_order_sel_in,
  input wire logic flow_through_sel_in,
  // Data pins
  input wire logic [LANES*LANE_W-1:0] byte_lane_data_in,
  output logic [LANES*LANE_W-1:0] byte_lane_data_out,
  output logic [LANES-1:0] byte_lane_data_oe_out,
  // Status
  output logic burst_active_out,
  output logic write_cycle_out
);

  localparam int DATA_W = LANES * LANE_W;
  localparam int BW = `SRAM_BURST_W;

  // Lanes to write for one sampled set of write controls
  function automatic logic [LANES-1:0] lane_mask(
    input logic gw_n,
    input logic we_n,
    input logic [LANES-1:0] bw_n
  );
    logic [LANES-1:0] mask;
    mask = '0;
    if (!gw_n)
      mask = '1; // [R12]
    else if (!we_n)
      mask = ~bw_n; // [R11] [R12]
    return mask;
  endfunction : lane_mask

  cycle_type state;
  cycle_type next_state;
  logic [ADDR_W-1:BW] addr_hi;
  logic [BW-1:0] addr_lsb;
  logic [ADDR_W-1:0] cur_addr;
  logic [LANES-1:0] lanes_q;
  logic [LANES-1:0] next_lanes;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] pipe_data;
  logic pipe_valid;

  // Strobe and enable decode on the raw pins, captured at the edge
  wire chip_sel_ok = !chip_en_primary_n_in && chip_en_depth_hi_in
                     && !chip_en_depth_lo_n_in; // [R16]
  wire proc_start = !proc_addr_strobe_n_in && !chip_en_primary_n_in; // [R3] [R15]
  wire strobe_seen = proc_start || !ctrl_addr_strobe_n_in; // [R2] [R15]
  wire start_cycle = strobe_seen && chip_sel_ok; // [R16]
  wire burst_step = !strobe_seen && !burst_advance_n_in
                    && state != CYCLE_IDLE; // [R4]
  wire [LANES-1:0] req_lanes = lane_mask(global_write_n_in, write_en_n_in,
                                         byte_write_n_in);
  wire write_req = |req_lanes; // [R13]

  // Straps are static and read directly
  wire pipelined = flow_through_sel_in != `SRAM_MODE_FLOW; // [R8]
  wire read_now = state == CYCLE_READ;
  // Address that the array sees stays put across the coming edge
  wire addr_kept = start_cycle ? addr_in == cur_addr : !burst_step;

  // Next cycle kind
  always_comb
  begin
    next_state = state;
    if (strobe_seen)
    begin
      if (!chip_sel_ok)
        next_state = CYCLE_IDLE; // [R2] [R15] [R16]
      else if (proc_start || !write_req)
        next_state = CYCLE_READ; // [R21]
      else
        next_state = CYCLE_WRITE; // [R21]
    end
    else
    begin
      unique case (state)
        CYCLE_IDLE: next_state = CYCLE_IDLE;
        CYCLE_READ, CYCLE_WRITE: next_state = write_req ? CYCLE_WRITE : CYCLE_READ; // [R13]
        default: next_state = CYCLE_IDLE;
      endcase
    end
  end

  assign next_lanes = (next_state == CYCLE_WRITE) ? req_lanes : `SRAM_LANES_RST;

  // Cycle state and write lanes
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state <= CYCLE_IDLE;
      lanes_q <= `SRAM_LANES_RST;
    end
    else
    begin
      state <= next_state; // [R1]
      lanes_q <= next_lanes; // [R1]
    end
  end

  // Upper address loads on a started access and holds through the burst
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      addr_hi <= (ADDR_W-BW)'(`SRAM_ADDR_RST >> BW);
    else if (start_cycle)
      addr_hi <= addr_in[ADDR_W-1:BW]; // [R1] [R5]
  end

  // Write data registers every edge
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      wdata_q <= `SRAM_DATA_RST;
    else
      wdata_q <= byte_lane_data_in; // [R1]
  end

  // Low address bits come from the burst counter
  burst_counter #(
    .BURST_W(BW)
  ) u_burst (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .load_in(start_cycle), // [R2] [R3]
    .step_in(burst_step), // [R4]
    .order_in(burst_order_sel_in), // [R7] [R22]
    .start_in(addr_in[BW-1:0]), // [R5]
    .lsb_out(addr_lsb)
  );

  assign cur_addr = {addr_hi, addr_lsb};

  // Registered lanes commit at the next edge, no external pulse
  lane_memory #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .ref_clk_in(ref_clk_in),
    .wr_lanes_in(lanes_q), // [R14]
    .addr_in(cur_addr), // [R20]
    .wr_data_in(wdata_q),
    .rd_data_out(mem_rd)
  );

  // Output register for pipelined reads
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      pipe_data <= `SRAM_DATA_RST;
      pipe_valid <= 1'b0;
    end
    else
    begin
      pipe_data <= mem_rd; // [R9]
      pipe_valid <= read_now; // [R9]
    end
  end

  // Data pins: flow-through bypasses the output register
  assign byte_lane_data_out = pipelined ? pipe_data : mem_rd; // [R9] [R10]
  assign byte_lane_data_oe_out = {LANES{(pipelined ? pipe_valid : read_now)
                                        && !output_en_n_in}}; // [R17]

  // Status flops
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      burst_active_out <= 1'b0;
      write_cycle_out <= 1'b0;
    end
    else
    begin
      burst_active_out <= next_state != CYCLE_IDLE;
      write_cycle_out <= next_state == CYCLE_WRITE;
    end
  end

  // Checks on the access logic
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_load_lin;
    start_cycle && burst_order_sel_in == `SRAM_ORDER_LINEAR;
  endsequence

  sequence s_load_il;
    start_cycle && burst_order_sel_in != `SRAM_ORDER_LINEAR;
  endsequence

  sequence s_three_steps;
    burst_step [*3];
  endsequence

  a_strobe_load: assert property ( // [R2]
    start_cycle |=> cur_addr == $past(addr_in))
    else $error("started access did not load the external address");

  a_proc_ignored: assert property ( // [R3]
    !proc_addr_strobe_n_in && chip_en_primary_n_in && ctrl_addr_strobe_n_in
    && state == CYCLE_IDLE |=> state == CYCLE_IDLE)
    else $error("processor strobe acted while primary enable high");

  a_burst_hold: assert property ( // [R4]
    !strobe_seen && burst_advance_n_in |=> $stable(cur_addr))
    else $error("burst address moved without advance");

  a_upper_stable: assert property ( // [R5]
    !start_cycle |=> $stable(cur_addr[ADDR_W-1:BW]))
    else $error("upper address changed within a burst");

  a_linear_order: assert property ( // [R7]
    s_load_lin ##1 s_three_steps |=>
      cur_addr[BW-1:0] == $past(addr_in[BW-1:0], 4) + 2'h3)
    else $error("linear burst sequence wrong");

  a_interleave_seq: assert property ( // [R22]
    s_load_il ##1 burst_step |=>
      cur_addr[BW-1:0] == ($past(addr_in[BW-1:0], 2) ^ `SRAM_BURST_STEP))
    else $error("interleaved second address wrong");

  a_interleave_last: assert property ( // [R22]
    s_load_il ##1 s_three_steps |=>
      cur_addr[BW-1:0] == ($past(addr_in[BW-1:0], 4) ^ 2'h3))
    else $error("interleaved fourth address wrong");

  a_pipe_latency: assert property ( // [R9]
    pipelined && read_now && !output_en_n_in |=>
      byte_lane_data_out == $past(mem_rd)
      && byte_lane_data_oe_out == {LANES{!output_en_n_in}})
    else $error("pipelined read not presented one edge later");

  a_flow_direct: assert property ( // [R10]
    !pipelined && read_now && !output_en_n_in |->
      byte_lane_data_out == mem_rd && byte_lane_data_oe_out == '1)
    else $error("flow-through read not driven in the same cycle");

  a_byte_lanes: assert property ( // [R11]
    !ctrl_addr_strobe_n_in && proc_addr_strobe_n_in && chip_sel_ok
    && global_write_n_in && !write_en_n_in |=> lanes_q == ~$past(byte_write_n_in))
    else $error("byte lane write mask wrong");

  a_global_write: assert property ( // [R12]
    start_cycle && !proc_start && !global_write_n_in |=> lanes_q == '1)
    else $error("global write did not select all lanes");

  a_read_no_write: assert property ( // [R13]
    state != CYCLE_IDLE && !strobe_seen && global_write_n_in && write_en_n_in
    |=> state == CYCLE_READ && lanes_q == '0)
    else $error("cycle without write inputs became a write");

  a_deselect: assert property ( // [R16]
    strobe_seen && !chip_sel_ok |=> state == CYCLE_IDLE ##1 !pipe_valid)
    else $error("bad enables did not deselect and float");

  a_oe_float: assert property ( // [R17]
    output_en_n_in |-> byte_lane_data_oe_out == '0)
    else $error("data pins driven while output enable high");

  a_proc_read: assert property ( // [R21]
    proc_start && chip_sel_ok |=> state == CYCLE_READ && lanes_q == '0)
    else $error("processor strobe cycle was not a read");

  a_write_continue: assert property ( // [R13]
    state != CYCLE_IDLE && !strobe_seen && write_req
    |=> state == CYCLE_WRITE && lanes_q == $past(req_lanes))
    else $error("continuation with write inputs did not write");

  a_burst_step: assert property ( // [R4]
    burst_step |=> cur_addr[BW-1:0] != $past(cur_addr[BW-1:0]))
    else $error("advance did not move the burst address");

  a_idle_hold: assert property ( // [R16]
    state == CYCLE_IDLE && !start_cycle |=> state == CYCLE_IDLE)
    else $error("deselected device left idle without an access");

  a_idle_float: assert property ( // [R16]
    state == CYCLE_IDLE && !(pipelined && pipe_valid) |-> byte_lane_data_oe_out == '0)
    else $error("data pins driven while deselected");

  // Each written lane reads back its new word once the address holds
  for (genvar j = 0; j < LANES; j++)
  begin : g_lane_check
    a_lane_commit: assert property ( // [R11] [R14]
      @(posedge ref_clk_in) disable iff (reset_in)
      state == CYCLE_WRITE && addr_kept && lanes_q[j] |=>
        mem_rd[j*LANE_W +: LANE_W] == $past(wdata_q[j*LANE_W +: LANE_W]))
      else $error("written lane did not commit at the next edge");
  end

endmodule : burst_sram_access

// File: hdl/burst_sram_defines.svh
// Shared widths, reset values and strap encodings for the burst SRAM
`ifndef BURST_SRAM_DEFINES_SVH
`define BURST_SRAM_DEFINES_SVH

// Array organisation: 256K words of eight 9-bit lanes
`define SRAM_ADDR_W 18
`define SRAM_LANES 8
`define SRAM_LANE_W 9
`define SRAM_DATA_W 72

// Burst counter spans the two lowest address bits
`define SRAM_BURST_W 2
`define SRAM_BURST_STEP 2'h1

// Reset values
`define SRAM_ADDR_RST 18'h00000
`define SRAM_LANES_RST 8'h00
`define SRAM_DATA_RST 72'h000000000000000000

// Strap encodings
`define SRAM_ORDER_LINEAR 1'b0
`define SRAM_MODE_FLOW 1'b0

`endif

// File: hdl/burst_sram_pkg.sv
// Types shared by the burst SRAM access logic
package burst_sram_pkg;

  // Kind of cycle the device is in after each edge
  typedef enum logic [1:0] {
    CYCLE_IDLE,
    CYCLE_READ,
    CYCLE_WRITE
  } cycle_type;

endpackage : burst_sram_pkg

// File: hdl/burst_counter.sv
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/100ps
`include "burst_sram_defines.svh"

module burst_counter
  import burst_sram_pkg::*;
#(
  parameter int BURST_W = `SRAM_BURST_W
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Control
  input wire logic load_in,
  input wire logic step_in,
  input wire logic order_in,
  input wire logic [BURST_W-1:0] start_in,
  // Burst low address bits
  output logic [BURST_W-1:0] lsb_out
);

  logic [BURST_W-1:0] start_q;
  logic [BURST_W-1:0] count_q;

  // Load restarts the count, step advances it
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in || load_in)
    begin
      start_q <= reset_in ? '0 : start_in;
      count_q <= '0;
    end
    else if (step_in)
      count_q <= count_q + BURST_W'(1);
  end

  // Interleaved XORs the step count, linear adds with wrap
  assign lsb_out = (order_in == `SRAM_ORDER_LINEAR) ? start_q + count_q : start_q ^ count_q;

endmodule : burst_counter

// File: hdl/lane_memory.sv
// Byte-lane organised storage array with self-timed clocked writes
`timescale 1ns/100ps
`include "burst_sram_defines.svh"

module lane_memory
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int LANE_W = `SRAM_LANE_W
)
(
  // Clock
  input wire logic ref_clk_in,
  // Write side
  input wire logic [LANES-1:0] wr_lanes_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES*LANE_W-1:0] wr_data_in,
  // Read side
  output logic [LANES*LANE_W-1:0] rd_data_out
);

  // One array per lane so lanes write independently
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    logic [LANE_W-1:0] cells [0:(1<<ADDR_W)-1];

    always_ff @(posedge ref_clk_in)
    begin
      if (wr_lanes_in[i])
        cells[addr_in] <= wr_data_in[i*LANE_W +: LANE_W];
    end

    assign rd_data_out[i*LANE_W +: LANE_W] = cells[addr_in];
  end

endmodule : lane_memory

// File: testbench/host_bus_model.sv
// Cache controller model that drives the memory bus one cycle at a time
`timescale 1ns/100ps
module host_bus_model
(
  // Clock
  input wire logic ref_clk_in,
  // Bus outputs
  output logic [17:0] addr_out,
  output logic proc_n_out,
  output logic ctrl_n_out,
  output logic adv_n_out,
  output logic [2:0] en_out,
  output logic gw_n_out,
  output logic we_n_out,
  output logic [7:0] bw_n_out,
  output logic oe_n_out,
  output logic [71:0] data_out
);
  // Quiet bus at time zero
  initial
  begin
    {proc_n_out, ctrl_n_out, adv_n_out, gw_n_out, we_n_out, oe_n_out} = 6'h3F;
    en_out = 3'h2;
    bw_n_out = 8'hFF;
    addr_out = 18'h00000;
    data_out = 72'h000000000000000000;
  end

  // One bus cycle launched just after a rising edge
  task automatic cyc(input logic p, input logic c, input logic a, input logic [2:0] e,
    input logic gw, input logic we, input logic [7:0] bw, input logic [17:0] ad,
    input logic [71:0] d, input logic o);
    logic wr;
    wr = !gw || (!we && bw != 8'hFF);
    @(posedge ref_clk_in);
    proc_n_out <= p;
    ctrl_n_out <= c;
    adv_n_out <= a;
    en_out <= e;
    gw_n_out <= gw;
    we_n_out <= we;
    bw_n_out <= bw;
    addr_out <= ad; // Low two bits wired to the burst bits
    oe_n_out <= o | wr; // Output enable held off through writes
    data_out <= wr ? d : ~data_out; // Released pins show no stale value
  endtask : cyc
endmodule : host_bus_model

// File: testbench/burst_sram_access_tb_top.sv
// Self-checking bench comparing the burst SRAM against a cycle model
`timescale 1ns/100ps
module burst_sram_access_tb_top;
  import burst_sram_pkg::*;
  logic ref_clk_in, reset_in, order_sel, flow_sel;
  logic proc_n, ctrl_n, adv_n, gw_n, we_n, oe_n, active, wcyc;
  logic [17:0] addr, ad;
  logic [2:0] en;
  logic [7:0] bw_n, oe;
  logic [71:0] din, dout;
  logic [71:0] mem [int];
  logic [71:0] wdata, pdata;
  logic [7:0] lanes;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 84;
  int cycles = 0;
  int st = 0;
  int base = 0;
  int start = 0;
  int n = 0;
  int pvalid = 0;
  int pok = 0;

  // Device and bus partner
  burst_sram_access u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr),
    .proc_addr_strobe_n_in(proc_n), .ctrl_addr_strobe_n_in(ctrl_n),
    .burst_advance_n_in(adv_n), .chip_en_primary_n_in(en[2]), .chip_en_depth_hi_in(en[1]),
    .chip_en_depth_lo_n_in(en[0]), .global_write_n_in(gw_n), .write_en_n_in(we_n),
    .byte_write_n_in(bw_n), .output_en_n_in(oe_n), .burst_order_sel_in(order_sel),
    .flow_through_sel_in(flow_sel), .byte_lane_data_in(din), .byte_lane_data_out(dout),
    .byte_lane_data_oe_out(oe), .burst_active_out(active), .write_cycle_out(wcyc));
  host_bus_model u_host (.ref_clk_in(ref_clk_in), .addr_out(addr), .proc_n_out(proc_n),
    .ctrl_n_out(ctrl_n), .adv_n_out(adv_n), .en_out(en), .gw_n_out(gw_n), .we_n_out(we_n),
    .bw_n_out(bw_n), .oe_n_out(oe_n), .data_out(din));

  // Clock and hang guard
  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      $display("FAIL %0t timeout", $time);
      results();
    end
  end

  function automatic int cur();
    return base + (order_sel ? (start ^ n) : ((start + n) % 4));
  endfunction : cur

  // Reference model: commit last write, then take the new cycle
  always @(posedge ref_clk_in)
  begin
    int a;
    a = cur();
    pvalid = (st == 1) && !reset_in;
    pok = pvalid && mem.exists(a);
    if (pok) pdata = mem[a];
    if (st == 2)
    begin
      if (!mem.exists(a)) mem[a] = 'x;
      for (int i = 0; i < 8; i++)
        if (lanes[i]) mem[a][i*9 +: 9] = wdata[i*9 +: 9];
    end
    if (reset_in) st = 0;
    else if ((!proc_n && !en[2]) || !ctrl_n)
    begin
      base = addr & 18'h3FFFC;
      start = addr[1:0];
      n = 0;
      st = (en != 3'h2) ? 0 : (!proc_n && !en[2]) ? 1 : 3;
    end
    else if (st != 0)
    begin
      if (!adv_n) n = (n + 1) % 4;
      st = 3;
    end
    if (st == 3) st = (!gw_n || (!we_n && bw_n != 8'hFF)) ? 2 : 1;
    lanes = !gw_n ? 8'hFF : we_n ? 8'h00 : ~bw_n;
    wdata = din;
  end

  // Compare every settled output mid-cycle
  always @(negedge ref_clk_in)
  begin
    logic e;
    e = (flow_sel ? pvalid != 0 : st == 1) && !oe_n;
    if (!reset_in)
    begin
      chk_bit(active, st != 0, "active");
      chk_bit(wcyc, st == 2, "write cycle");
      chk_word({64'h0, oe}, {64'h0, {8{e}}}, "drive");
      if (e && flow_sel && pok) chk_word(dout, pdata, "pipe data");
      if (e && !flow_sel && mem.exists(cur())) chk_word(dout, mem[cur()], "data");
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s got %b", $time, what, got);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [71:0] got, input logic [71:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  // Write burst from the controller strobe, random data each beat
  task automatic wburst(input logic [17:0] a, input logic gw, input logic we,
    input logic [7:0] bw, input int k);
    for (int i = 0; i < k; i++)
      u_host.cyc(1'b1, i != 0, i == 0, 3'h2, gw, we, bw, a, 72'({$random(seed),
        $random(seed), $random(seed)}), 1'b0);
  endtask : wburst

  // Read burst from either strobe with advance
  task automatic rburst(input logic [17:0] a, input logic p, input int k, input logic o);
    for (int i = 0; i < k; i++)
      u_host.cyc(!(p && i == 0), p || i != 0, i == 0, 3'h2, 1'b1, 1'b1, 8'hFF, a, 72'h0, o);
  endtask : rburst

  // Reset with straps settled only while reset holds
  task automatic phase(input logic f, input logic o);
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    flow_sel <= f;
    order_sel <= o;
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 1'b0;
  endtask : phase

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Main sequence: flow-through linear, then pipelined interleaved
  initial
  begin
    {reset_in, flow_sel, order_sel} = 3'h4;
    for (int ph = 0; ph < 2; ph++)
    begin
      phase(ph[0], ph[0]);
      ad = 18'($random(seed)) | 18'h00002;
      wburst(ad, 1'b0, 1'b1, 8'hFF, 4);
      rburst(ad, 1'b1, 4, 1'b0);
      u_host.cyc(1'b1, 1'b1, 1'b1, 3'h2, 1'b1, 1'b1, 8'hFF, ad, 72'h0, 1'b0);
      for (int i = 0; i < 8; i++)
        wburst(ad, 1'b1, 1'b0, ~(8'h01 << i), 1);
      wburst(ad + 18'h1, 1'b1, 1'b0, 8'h00, 1);
      wburst(ad + 18'h1, 1'b1, 1'b1, 8'h00, 1);
      rburst(ad, 1'b0, 4, 1'b0);
      $display("test write and read bursts done");
      u_host.cyc(1'b0, 1'b1, 1'b1, 3'h2, 1'b0, 1'b0, 8'h00, ad, 72'h0, 1'b0);
      u_host.cyc(1'b0, 1'b1, 1'b0, 3'h6, 1'b1, 1'b1, 8'hFF, ad, 72'h0, 1'b0);
      u_host.cyc(1'b1, 1'b0, 1'b1, 3'h6, 1'b1, 1'b1, 8'hFF, ad, 72'h0, 1'b0);
      u_host.cyc(1'b0, 1'b1, 1'b0, 3'h6, 1'b1, 1'b1, 8'hFF, ad, 72'h0, 1'b0);
      rburst(ad, 1'b1, 2, 1'b0);
      u_host.cyc(1'b1, 1'b0, 1'b1, 3'h0, 1'b1, 1'b1, 8'hFF, ad, 72'h0, 1'b0);
      rburst(ad, 1'b0, 2, 1'b0);
      u_host.cyc(1'b0, 1'b1, 1'b1, 3'h3, 1'b1, 1'b1, 8'hFF, ad, 72'h0, 1'b0);
      rburst(ad, 1'b1, 3, 1'b1);
      rburst(ad, 1'b1, 2, 1'b0);
      $display("test selects and output enable done");
    end
    results();
  end
endmodule : burst_sram_access_tb_top
